// File: rtl/sad_decoder.sv
// system address decoder: routes core transfers and ends bad ones with an error
`timescale 1ns/100ps
module sad_decoder (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic xfer_valid,
    input wire logic [31:0] xfer_addr,
    input wire logic xfer_write,
    input wire logic [31:0] xfer_wdata,
    input wire logic [127:0] clk_gate_on,
    input wire logic [2:0] power_mode,
    input wire logic low_voltage_detect_event,
    output logic xfer_ready,
    output logic resp_valid,
    output logic resp_error,
    output logic [31:0] resp_rdata,
    output logic [9:0] dest_sel,
    output logic [127:0] slot_enable,
    output logic sram_retain
);
    typedef struct packed {
        logic [9:0] sel;
        logic [6:0] slot;
        logic slot_hit;
        logic bridge;
        logic regfile;
        logic err;
    } sad_dec_t;

    typedef struct packed {
        sad_pkg::sad_fsm_t fsm;
        logic [1:0] cnt;
        logic ready;
        logic resp;
        logic err;
        logic [31:0] rdata;
        logic [9:0] sel;
        logic [127:0] slot_en;
        logic retain;
    } sad_state_t;

    sad_state_t st_reg;
    sad_state_t st_next;
    sad_dec_t dec;
    logic take;

    sad_rf_if rf_link ();

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // slot check shared by the bridge window, the gpio alias and the bit-manipulation alias
    function automatic logic slot_ok(input logic [6:0] s, input logic [11:0] off, input logic [127:0] gate);
        logic [11:0] lim;
        lim = (s == sad_pkg::REGFILE_SLOT) ? sad_pkg::REGFILE_BYTES : sad_pkg::SLOT_IMPL_BYTES;
        slot_ok = sad_pkg::SLOT_IMPL_MASK[s] && gate[s] && (off < lim);
    endfunction : slot_ok

    // purely combinational: at most one select per address
    function automatic sad_dec_t decode(input logic [31:0] a, input logic [127:0] gate);
        sad_dec_t d;
        d = '0;
        d.slot = a[18:12];
        if (in_range(a, sad_pkg::FLASH_BASE, sad_pkg::FLASH_LAST))
        begin
            if (a < sad_pkg::FLASH_BYTES)
            begin
                d.sel[sad_pkg::SEL_FLASH] = 1'b1;
            end
            else
            begin
                d.err = 1'b1;
            end
        end
        else if (in_range(a, sad_pkg::ROM_BASE, sad_pkg::ROM_LAST))
        begin
            d.sel[sad_pkg::SEL_ROM] = 1'b1;
        end
        else if (in_range(a, sad_pkg::SRAM_L_BASE, sad_pkg::SRAM_SPLIT - 32'h1))
        begin
            d.sel[sad_pkg::SEL_SRAM_L] = 1'b1;
        end
        else if (in_range(a, sad_pkg::SRAM_SPLIT, sad_pkg::SRAM_U_LAST))
        begin
            d.sel[sad_pkg::SEL_SRAM_U] = 1'b1;
        end
        else if (in_range(a, sad_pkg::BRIDGE_BASE, sad_pkg::BRIDGE_SLOTS_LAST))
        begin
            d.bridge = 1'b1;
            if (slot_ok(a[18:12], a[11:0], gate))
            begin
                d.sel[sad_pkg::SEL_BRIDGE] = 1'b1;
                d.slot_hit = 1'b1;
                d.regfile = (a[18:12] == sad_pkg::REGFILE_SLOT);
            end
            else
            begin
                d.err = 1'b1;
            end
        end
        else if (in_range(a, sad_pkg::GPIO_ALIAS_BASE, sad_pkg::BRIDGE_LAST))
        begin
            d.slot = sad_pkg::GPIO_SLOT;
            if (slot_ok(sad_pkg::GPIO_SLOT, a[11:0], gate))
            begin
                d.sel[sad_pkg::SEL_GPIO] = 1'b1;
            end
            else
            begin
                d.err = 1'b1;
            end
        end
        else if (in_range(a, sad_pkg::BITALIAS_BASE, sad_pkg::BITALIAS_LAST))
        begin
            // decorated address: bits above the 1 mb window carry the operation
            if (a[19] == 1'b0 && slot_ok(a[18:12], a[11:0], gate))
            begin
                d.sel[sad_pkg::SEL_BITALIAS] = 1'b1;
                d.slot_hit = 1'b1;
            end
            else
            begin
                d.err = 1'b1;
            end
        end
        else if (in_range(a, sad_pkg::PRIV_BASE, sad_pkg::PRIV_LAST))
        begin
            d.sel[sad_pkg::SEL_PRIV] = 1'b1;
        end
        else if (in_range(a, sad_pkg::CORE_LOCAL_BASE, sad_pkg::CORE_LOCAL_LAST))
        begin
            d.sel[sad_pkg::SEL_CORE_LOCAL] = 1'b1;
        end
        else if (a >= sad_pkg::SINGLE_CYCLE_IO_PORT_BASE)
        begin
            d.sel[sad_pkg::SEL_SINGLE_CYCLE_IO_PORT] = 1'b1;
        end
        else
        begin
            d.err = 1'b1;
        end
        decode = d;
    endfunction : decode

    assign take = xfer_valid && st_reg.ready && (st_reg.fsm == sad_pkg::ST_IDLE);
    assign dec = decode(xfer_addr, clk_gate_on);

    assign rf_link.wr_en = take && dec.regfile && xfer_write;
    assign rf_link.word = xfer_addr[3:2];
    assign rf_link.wdata = xfer_wdata;

    sad_regfile u_regfile (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rf(rf_link.rf)
    );

    always_comb
    begin
        st_next = st_reg;
        st_next.retain = !(power_mode == sad_pkg::PM_LOW_LEAKAGE_STOP_ONE ||
            power_mode == sad_pkg::PM_LOW_LEAKAGE_STOP_ZERO);
        case (st_reg.fsm)
            sad_pkg::ST_IDLE:
            begin
                st_next.resp = 1'b0;
                if (take)
                begin
                    st_next.ready = 1'b0;
                    st_next.err = dec.err;
                    st_next.sel = dec.sel;
                    st_next.slot_en = '0;
                    st_next.slot_en[dec.slot] = dec.slot_hit;
                    st_next.rdata = (dec.regfile && !xfer_write) ? rf_link.rdata : 32'h0;
                    if (dec.bridge && !dec.err)
                    begin
                        st_next.fsm = sad_pkg::ST_WAIT;
                        st_next.cnt = sad_pkg::BRIDGE_WAIT;
                    end
                    else
                    begin
                        st_next.fsm = sad_pkg::ST_DONE;
                        st_next.resp = 1'b1;
                    end
                end
            end
            sad_pkg::ST_WAIT:
            begin
                if (st_reg.cnt <= 2'h1)
                begin
                    st_next.fsm = sad_pkg::ST_DONE;
                    st_next.resp = 1'b1;
                end
                else
                begin
                    st_next.cnt = st_reg.cnt - 2'h1;
                end
            end
            sad_pkg::ST_DONE:
            begin
                st_next.fsm = sad_pkg::ST_IDLE;
                st_next.resp = 1'b0;
                st_next.err = 1'b0;
                st_next.sel = '0;
                st_next.slot_en = '0;
                st_next.rdata = 32'h0;
                st_next.ready = 1'b1;
            end
            default:
            begin
                st_next.fsm = sad_pkg::ST_IDLE;
                st_next.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '{fsm: sad_pkg::ST_IDLE, cnt: 2'h0, ready: 1'b1, resp: 1'b0, err: 1'b0,
                rdata: 32'h0, sel: 10'h0, slot_en: 128'h0, retain: 1'b1};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign xfer_ready = st_reg.ready;
    assign resp_valid = st_reg.resp;
    assign resp_error = st_reg.err;
    assign resp_rdata = st_reg.rdata;
    assign dest_sel = st_reg.sel;
    assign slot_enable = st_reg.slot_en;
    assign sram_retain = st_reg.retain;

    chk_one_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $onehot0({st_reg.sel, st_reg.err}) && $onehot0(st_reg.slot_en))
        else $error("more than one destination selected");
    chk_vector_fetch: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && xfer_addr < sad_pkg::VECTOR_BYTES |=> dest_sel[sad_pkg::SEL_FLASH] && !resp_error)
        else $error("vector fetch not routed to flash");
    chk_flash_past: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && xfer_addr >= sad_pkg::FLASH_BYTES && xfer_addr <= sad_pkg::FLASH_LAST
        |=> resp_valid && resp_error && dest_sel == 10'h0)
        else $error("access past flash not errored");
    chk_sram_edges: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && (xfer_addr == 32'h1fff_fe00 || xfer_addr == 32'h2000_05ff)
        |=> !resp_error && (dest_sel[sad_pkg::SEL_SRAM_L] || dest_sel[sad_pkg::SEL_SRAM_U]))
        else $error("sram edge address not routed");
    chk_sram_beyond: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && (xfer_addr == 32'h1fff_fdff || xfer_addr == 32'h2000_0600) |=> resp_valid && resp_error)
        else $error("access beyond sram not errored");
    chk_gated_slot: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && xfer_addr[31:19] == 13'h0800 && !clk_gate_on[xfer_addr[18:12]]
        |=> resp_valid && resp_error && slot_enable == 128'h0)
        else $error("gated slot reached");
    chk_gpio_direct: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && xfer_addr[31:12] == 20'h400ff && clk_gate_on[15] && xfer_addr[11:0] < 12'h100
        |=> resp_valid && dest_sel[sad_pkg::SEL_GPIO])
        else $error("gpio alias not served directly");
    chk_bridge_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && dec.bridge && !dec.err |=> !resp_valid && !xfer_ready ##1 resp_valid ##1 xfer_ready)
        else $error("bridge transfer timing wrong");
    chk_alias_slot: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && dec.sel[sad_pkg::SEL_BITALIAS] |=> slot_enable[$past(xfer_addr[18:12])] && resp_valid)
        else $error("alias access missed its slot");
    chk_reserved_err: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && xfer_addr >= 32'h6000_0000 && xfer_addr < sad_pkg::PRIV_BASE |=> resp_error)
        else $error("reserved access not errored");
    chk_retain_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
        power_mode == sad_pkg::PM_LOW_LEAKAGE_STOP_ONE || power_mode == sad_pkg::PM_LOW_LEAKAGE_STOP_ZERO
        |=> !sram_retain)
        else $error("sram retention wrong for power mode");
    chk_retain_deep: assert property (@(posedge sys_clk) disable iff (sys_rst)
        power_mode <= sad_pkg::PM_DEEPEST_RETAINING_STOP |=> sram_retain)
        else $error("sram not retained in a retaining mode");
    chk_bridge_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && dec.sel[sad_pkg::SEL_BRIDGE]
        |=> slot_enable[$past(xfer_addr[18:12])] && dest_sel[sad_pkg::SEL_BRIDGE] && !resp_error)
        else $error("bridge slot enable missing");
    chk_direct_resp: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && !(dec.bridge && !dec.err) |=> resp_valid && !xfer_ready ##1 !resp_valid && xfer_ready)
        else $error("direct transfer timing wrong");
    chk_single_cycle_io_port_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && xfer_addr >= sad_pkg::SINGLE_CYCLE_IO_PORT_BASE |=> resp_valid && dest_sel[sad_pkg::SEL_SINGLE_CYCLE_IO_PORT])
        else $error("io port access not routed");
    chk_rom_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && xfer_addr >= sad_pkg::ROM_BASE && xfer_addr <= sad_pkg::ROM_LAST
        |=> resp_valid && dest_sel[sad_pkg::SEL_ROM] && !resp_error)
        else $error("boot rom access not routed");
    chk_lvd_keeps: assert property (@(posedge sys_clk) disable iff (sys_rst)
        low_voltage_detect_event && !rf_link.wr_en |=> $stable(u_regfile.st_reg))
        else $error("register file disturbed by voltage event");
endmodule : sad_decoder

// File: rtl/sad_pkg.sv
// constants and types shared by the system address decoder
// Overview of operation
// - sram splits one quarter into the lower range, three quarters upper
// - lower sram ends at 0x1fff_ffff, upper starts at 0x2000_0000, contiguous
// - 2 kb sram: lower 0x1fff_fe00-0x1fff_ffff, upper 0x2000_0000-0x2000_05ff
// - access inside an sram range beyond implemented ram gets a bus error
// - flash starts at zero; flash-region access past implemented flash errors
// - flash region spans to 0x07ff_ffff; first 196 bytes hold vectors
// - boot rom at 0x1c00_0000-0x1c00_1fff, private space 0xe000_0000-0xe00f_ffff
// - every address of the 4 gb space decodes to at most one range; an address in no range ends in error
// - 0x4400_0000 region aliases bridge slots 0-127 for atomic updates
// - range from 0xf800_0000 gives single-cycle io port access
// - bridge on one crossbar port decodes 1024 kb at 0x4000_0000-0x400f_ffff
// - first 128 kb of bridge: 32 slots of 4 kb, each own enable
// - next 384 kb: 96 slots of 4 kb, each own enable
// - slot 255 at 0x400f_f000 aliases slot 15, the gpio registers
// - aliased gpio slot served directly, no bridge wait states
// - cleared clock gate bit disables that module's bridge slot
// - access to an unimplemented or disabled slot ends in transfer error
// - unimplemented offset within an enabled slot ends in transfer error
// - sram retained down to deepest retaining stop, lost in two lower modes
// - a 16-byte register file stays powered in every mode
// - register file survives voltage-detect events, cleared only by power-on reset
package sad_pkg;
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_LAST = 32'h07ff_ffff;
    localparam logic [31:0] FLASH_BYTES = 32'h0000_8000;
    localparam logic [31:0] VECTOR_BYTES = 32'h0000_00c4;
    localparam logic [31:0] ROM_BASE = 32'h1c00_0000;
    localparam logic [31:0] ROM_LAST = 32'h1c00_1fff;
    localparam logic [31:0] SRAM_BYTES = 32'h0000_0800;
    localparam logic [31:0] SRAM_SPLIT = 32'h2000_0000;
    localparam logic [31:0] SRAM_L_BASE = SRAM_SPLIT - (SRAM_BYTES >> 2);
    localparam logic [31:0] SRAM_U_LAST = SRAM_SPLIT + (SRAM_BYTES - (SRAM_BYTES >> 2)) - 32'h1;
    localparam logic [31:0] BRIDGE_BASE = 32'h4000_0000;
    localparam logic [31:0] BRIDGE_SLOTS_LAST = 32'h4007_ffff;
    localparam logic [31:0] GPIO_ALIAS_BASE = 32'h400f_f000;
    localparam logic [31:0] BRIDGE_LAST = 32'h400f_ffff;
    localparam logic [31:0] BITALIAS_BASE = 32'h4400_0000;
    localparam logic [31:0] BITALIAS_LAST = 32'h5fff_ffff;
    localparam logic [31:0] PRIV_BASE = 32'he000_0000;
    localparam logic [31:0] PRIV_LAST = 32'he00f_ffff;
    localparam logic [31:0] CORE_LOCAL_BASE = 32'hf000_0000;
    localparam logic [31:0] CORE_LOCAL_LAST = 32'hf000_3fff;
    localparam logic [31:0] SINGLE_CYCLE_IO_PORT_BASE = 32'hf800_0000;
    localparam int SLOT_COUNT = 128;
    localparam logic [6:0] GPIO_SLOT = 7'h0f;
    localparam logic [6:0] REGFILE_SLOT = 7'h41;
    localparam logic [11:0] SLOT_IMPL_BYTES = 12'h100;
    localparam logic [11:0] REGFILE_BYTES = 12'h010;
    // slots populated in this device: 15, 32, 56, 57, 59, 61, 64, 65, 71, 72
    localparam logic [127:0] SLOT_IMPL_MASK = 128'h0000_0000_0000_0183_2b00_0001_0000_8000;
    localparam logic [1:0] BRIDGE_WAIT = 2'h1;
    localparam logic [31:0] REGFILE_RESET = 32'h0000_0000;

    // one-hot destination select positions
    localparam int SEL_FLASH = 0;
    localparam int SEL_ROM = 1;
    localparam int SEL_SRAM_L = 2;
    localparam int SEL_SRAM_U = 3;
    localparam int SEL_BRIDGE = 4;
    localparam int SEL_GPIO = 5;
    localparam int SEL_BITALIAS = 6;
    localparam int SEL_PRIV = 7;
    localparam int SEL_CORE_LOCAL = 8;
    localparam int SEL_SINGLE_CYCLE_IO_PORT = 9;
    localparam int SEL_W = 10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_DONE = 2'h3
    } sad_fsm_t;

    typedef enum logic [2:0] {
        PM_RUN = 3'h0,
        PM_STOP = 3'h1,
        PM_LOW_LEAK_STOP = 3'h2,
        PM_DEEPEST_RETAINING_STOP = 3'h3,
        PM_LOW_LEAKAGE_STOP_ONE = 3'h4,
        PM_LOW_LEAKAGE_STOP_ZERO = 3'h5
    } sad_pmode_t;
endpackage : sad_pkg

// File: rtl/sad_regfile.sv
// sixteen-byte register file, cleared only by power-on reset
`timescale 1ns/100ps
module sad_regfile (
    input wire logic sys_clk,
    input wire logic sys_rst,
    sad_rf_if.rf rf
);
    typedef struct packed {
        logic [3:0][31:0] word;
    } sad_rf_state_t;

    sad_rf_state_t st_reg;
    sad_rf_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (rf.wr_en)
        begin
            st_next.word[rf.word] = rf.wdata;
        end
    end

    // only the power-on reset clears; voltage-detect events never reach here
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '{word: {4{sad_pkg::REGFILE_RESET}}};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rf.rdata = st_reg.word[rf.word];

    chk_rf_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rf.wr_en |=> st_reg.word[$past(rf.word)] == $past(rf.wdata))
        else $error("register file write lost");
    chk_rf_hold_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !rf.wr_en |=> st_reg == $past(st_reg))
        else $error("register file changed without a write");
endmodule : sad_regfile

// File: rtl/sad_rf_if.sv
// link between the decoder and the always-powered register file
`timescale 1ns/100ps
interface sad_rf_if;
    logic wr_en;
    logic [1:0] word;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport dec (output wr_en, output word, output wdata, input rdata);
    modport rf (input wr_en, input word, input wdata, output rdata);
endinterface : sad_rf_if

// File: testbench/sad_core_master.sv
// core-side bus master model: one load or store at a time, released lines show inverted values
`timescale 1ns/100ps
module sad_core_master (
    input wire logic sys_clk,
    output logic xfer_valid,
    output logic [31:0] xfer_addr,
    output logic xfer_write,
    output logic [31:0] xfer_wdata,
    input wire logic xfer_ready,
    input wire logic resp_valid,
    input wire logic resp_error,
    input wire logic [31:0] resp_rdata,
    input wire logic [9:0] dest_sel,
    input wire logic [127:0] slot_enable
);
    initial
    begin
        xfer_valid = 1'b0;
        xfer_addr = 32'h0000_0000;
        xfer_write = 1'b0;
        xfer_wdata = 32'h0000_0000;
    end

    task automatic run_xfer(input logic [31:0] addr, input logic write, input logic [31:0] wdata,
        output logic err, output logic [31:0] rdata, output logic [9:0] sel, output logic [127:0] slot,
        output int lat, output logic hung);
        int waits;
        waits = 0;
        @(posedge sys_clk);
        #1;
        xfer_valid = 1'b1;
        xfer_addr = addr;
        xfer_write = write;
        xfer_wdata = wdata;
        // request stands until it is taken on an edge with ready high, or is dropped as hung after 8 waits
        while (xfer_ready !== 1'b1 && waits < 8)
        begin
            @(posedge sys_clk);
            #1;
            waits++;
        end
        hung = (xfer_ready !== 1'b1);
        @(posedge sys_clk);
        #1;
        xfer_valid = 1'b0;
        xfer_addr = ~addr;
        xfer_write = ~write;
        xfer_wdata = ~wdata;
        lat = 1;
        sel = dest_sel;
        slot = slot_enable;
        while (resp_valid !== 1'b1 && lat < 8)
        begin
            @(posedge sys_clk);
            #1;
            lat++;
        end
        if (resp_valid !== 1'b1)
            hung = 1'b1;
        err = resp_error;
        rdata = resp_rdata;
    endtask : run_xfer
endmodule : sad_core_master

// File: testbench/tb_system_address_decoder.sv
// self-checking bench for the system address decoder
`timescale 1ns/100ps
module tb_system_address_decoder;
    logic sys_clk, sys_rst, xfer_valid, xfer_write, xfer_ready, resp_valid, resp_error, volt_evt, sram_retain;
    logic [31:0] xfer_addr, xfer_wdata, resp_rdata;
    logic [9:0] dest_sel;
    logic [127:0] clk_gate_on, slot_enable;
    logic [2:0] power_mode;
    logic [31:0] rf_model [4];
    logic [31:0] edges [39] = '{32'h0, 32'hc0, 32'h7ffc, 32'h8000, 32'h07ff_ffff, 32'h0800_0000, 32'h1bff_ffff,
        32'h1c00_0000, 32'h1c00_1fff, 32'h1c00_2000, 32'h1fff_fdff, 32'h1fff_fe00, 32'h1fff_ffff, 32'h2000_0000,
        32'h2000_05ff, 32'h2000_0600, 32'h3fff_ffff, 32'h4007_ffff, 32'h4008_0000, 32'h400f_efff, 32'h400f_f000,
        32'h400f_ffff, 32'h4010_0000, 32'h43ff_ffff, 32'h4400_0000, 32'h4402_0000, 32'h5fff_ffff, 32'h6000_0000,
        32'hdfff_ffff, 32'he000_0000, 32'he00f_ffff, 32'he010_0000, 32'hefff_ffff, 32'hf000_0000, 32'hf000_3fff,
        32'hf000_4000, 32'hf7ff_ffff, 32'hf800_0000, 32'hffff_ffff};
    int fail_count = 0;
    int n_compared = 0;

    sad_decoder u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .xfer_valid(xfer_valid), .xfer_addr(xfer_addr),
        .xfer_write(xfer_write), .xfer_wdata(xfer_wdata), .clk_gate_on(clk_gate_on), .power_mode(power_mode),
        .low_voltage_detect_event(volt_evt), .xfer_ready(xfer_ready), .resp_valid(resp_valid),
        .resp_error(resp_error), .resp_rdata(resp_rdata), .dest_sel(dest_sel), .slot_enable(slot_enable),
        .sram_retain(sram_retain));

    sad_core_master u_master (.sys_clk(sys_clk), .xfer_valid(xfer_valid), .xfer_addr(xfer_addr),
        .xfer_write(xfer_write), .xfer_wdata(xfer_wdata), .xfer_ready(xfer_ready), .resp_valid(resp_valid),
        .resp_error(resp_error), .resp_rdata(resp_rdata), .dest_sel(dest_sel), .slot_enable(slot_enable));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic cmp_val(input string nm, input logic [127:0] exp, input logic [127:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp_val

    // reference decode of one address against the current clock gates
    function automatic void predict(input logic [31:0] a, output logic [9:0] s, output logic [127:0] sl,
        output int lt);
        logic [6:0] n;
        logic ok;
        n = a[18:12];
        ok = (n inside {7'h0f, 7'h20, 7'h38, 7'h39, 7'h3b, 7'h3d, 7'h40, 7'h41, 7'h47, 7'h48}) && clk_gate_on[n]
            && a[11:0] < ((n == 7'h41) ? 12'h010 : 12'h100);
        s = '0;
        sl = '0;
        lt = 1;
        if (a <= 32'h07ff_ffff)
            s[0] = (a < 32'h0000_8000);
        else if (a >= 32'h1c00_0000 && a <= 32'h1c00_1fff)
            s[1] = 1'b1;
        else if (a >= 32'h1fff_fe00 && a <= 32'h1fff_ffff)
            s[2] = 1'b1;
        else if (a >= 32'h2000_0000 && a <= 32'h2000_05ff)
            s[3] = 1'b1;
        else if (a >= 32'h4000_0000 && a <= 32'h4007_ffff && ok)
        begin
            s[4] = 1'b1;
            sl[n] = 1'b1;
            lt = 2;
        end
        else if (a >= 32'h400f_f000 && a <= 32'h400f_ffff)
            s[5] = clk_gate_on[15] && a[11:0] < 12'h100;
        else if (a >= 32'h4400_0000 && a <= 32'h5fff_ffff && !a[19] && ok)
        begin
            s[6] = 1'b1;
            sl[n] = 1'b1;
        end
        else if (a >= 32'he000_0000 && a <= 32'he00f_ffff)
            s[7] = 1'b1;
        else if (a >= 32'hf000_0000 && a <= 32'hf000_3fff)
            s[8] = 1'b1;
        else if (a >= 32'hf800_0000)
            s[9] = 1'b1;
    endfunction : predict

    task automatic check_xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        logic ge, hung;
        logic [9:0] s, gs;
        logic [127:0] sl, gsl;
        logic [31:0] rd, gr;
        int lt, gl;
        predict(a, s, sl, lt);
        rd = 32'h0000_0000;
        if (s[4] && sl[65] && w)
            rf_model[a[3:2]] = d;
        else if (s[4] && sl[65])
            rd = rf_model[a[3:2]];
        u_master.run_xfer(a, w, d, ge, gr, gs, gsl, gl, hung);
        if (hung)
        begin
            fail_count++;
            wrap_up();
        end
        cmp_val("resp_error", (s == 10'h000), ge);
        cmp_val("dest_sel", s, gs);
        cmp_val("slot_enable", sl, gsl);
        cmp_val("resp_rdata", rd, gr);
        cmp_val("latency", lt, gl);
    endtask : check_xfer

    initial
    begin
        sys_rst = 1'b1;
        clk_gate_on = '1;
        power_mode = 3'h0;
        volt_evt = 1'b0;
        rf_model = '{default: 32'h0};
        void'($urandom(4804));
        repeat (20) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        foreach (edges[i])
            check_xfer(edges[i], 1'b0, 32'h0);
        for (int p = 0; p < 2; p++)
        begin
            if (p == 1)
                clk_gate_on = {$urandom(), $urandom(), $urandom(), $urandom()};
            for (int i = 0; i < 128; i++)
            begin
                check_xfer(32'h4000_00fc + i * 4096, 1'b0, 32'h0);
                check_xfer(32'h4000_0100 + i * 4096, 1'b0, 32'h0);
                if (i != 65)
                    check_xfer(32'h4400_0000 + i * 4096, 1'b0, 32'h0);
            end
            check_xfer(32'h400f_f0fc, 1'b0, 32'h0);
            check_xfer(32'h400f_f100, 1'b0, 32'h0);
        end
        clk_gate_on = '1;
        repeat (150)
            check_xfer(edges[$urandom_range(38)] ^ ($urandom() & 32'h0000_1fff), 1'b0, 32'h0);
        for (int i = 0; i < 4; i++)
            check_xfer(32'h4004_1000 + i * 4, 1'b1, $urandom());
        volt_evt = 1'b1;
        check_xfer(32'h4004_1010, 1'b0, 32'h0);
        volt_evt = 1'b0;
        for (int i = 0; i < 4; i++)
            check_xfer(32'h4004_1000 + i * 4, 1'b0, 32'h0);
        clk_gate_on[65] = 1'b0;
        check_xfer(32'h4004_1000, 1'b0, 32'h0);
        clk_gate_on[65] = 1'b1;
        sys_rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        rf_model = '{default: 32'h0};
        for (int i = 0; i < 4; i++)
            check_xfer(32'h4004_1000 + i * 4, 1'b0, 32'h0);
        for (int m = 0; m < 6; m++)
        begin
            power_mode = m[2:0];
            repeat (2) @(posedge sys_clk);
            #1;
            cmp_val("sram_retain", (m < 4), sram_retain);
        end
        check_xfer(32'h2000_0000, 1'b0, 32'h0);
        wrap_up();
    end
endmodule : tb_system_address_decoder
